// ### hdl/spe_protect_status.sv
// Serial slave front end with status register and write protection
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Raising chip select ends the operation or starts the internal write.
// - Chip select high puts device in standby with output released.
// - Mode 0 and 3: sample on rising edge, shift out on falling.
// - Hardware protection blocks changes to guard and arm bits.
// - Hardware protection is guard pin low and arm bit set.
// - Pause low freezes the transfer; it resumes where it stopped.
// - Pause tied high never interrupts a transfer.
// - Status register read-only under hardware protection or clear latch.
// - Bit 0 is busy; while busy only status and array reads are taken.
// - Bit 1 write latch gates all changes; cleared at reset, set by command.
// - Bits 2 and 3 hold region guard, zero from the factory.
// - Bits 4 to 6 store nothing, read zero except during write.
// - Bit 7 arms pin guard; it never protects the array.
// - Arm bit cannot fall from one to zero while guard pin low.
// - During the internal write every status bit reads one.
// - Region code selects none, C0h-FFh, 80h-FFh or whole array.
// - Latch set and no hardware guard allows status change; array per region.
// - Latch clears after clear command or at the end of an accepted status or array write.
// - Status write keeps only guard and arm bits.
module spe_protect_status
   import spe_pkg::*;
#(
   parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
   // System clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Serial link, clocked by its own serial clock
   input  wire logic              serialClk,
   input  wire logic              chipSelectN,
   input  wire logic              serialIn,
   input  wire logic              pauseN,
   output logic                   serialOut,
   output logic                   serialOutEn,
   // Write-guard pin
   input  wire logic              writeGuardN,
   // Array side
   output logic                   arrayWriteReq,
   output logic [ADDR_W-1:0]      arrayWriteAddr,
   output logic [7:0]             arrayWriteData,
   input  wire logic [7:0]        arrayReadData,
   // Status view
   output logic [7:0]             protectionStatus
);
   // ------------------------------------------------------------
   // Synchronised pins in the system domain
   // ------------------------------------------------------------
   logic csSync, guardSync, csLast;

   spe_sync #(.WIDTH(2), .INIT(2'h3)) uPins (
      .clk  (clk),
      .rst  (sys_rst),
      .din  ({chipSelectN, writeGuardN}),
      .dout ({csSync, guardSync})
   );

   // ------------------------------------------------------------
   // Link domain: shifter, runs on serial clock edges
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LS_OPCODE = 2'b00,
      LS_ADDR   = 2'b01,
      LS_DATA   = 2'b10,
      LS_READ   = 2'b11
   } spe_link_t;

   spe_link_t         linkState;
   logic [7:0]        shiftIn;
   logic [2:0]        bitCnt;
   logic [2:0]        opcode;
   logic              opValid;
   logic [ADDR_W-1:0] linkAddr;
   logic [7:0]        linkData;
   logic              dataSeen;
   logic [7:0]        txByte;
   logic [7:0]        txShift;
   logic              txActive;
   logic [7:0]        statusView;
   logic [7:0]        statusLink0, statusLink;
   logic [7:0]        arrayLink0, arrayLink;
   logic [7:0]        nextByte;

   // Status and array data crossed as slow words; stable during reads
   always_ff @(posedge serialClk)
   begin
      statusLink0 <= statusView;
      statusLink  <= statusLink0;
      arrayLink0  <= arrayReadData;
      arrayLink   <= arrayLink0;
   end

   assign nextByte = {shiftIn[6:0], serialIn};

   // Sampling on rising edge; pause freezes, chip select resets
   always_ff @(posedge serialClk or posedge chipSelectN)
   begin
      if (chipSelectN)
      begin
         linkState <= LS_OPCODE;
         bitCnt    <= 3'h0;
         shiftIn   <= 8'h00;
      end
      else if (pauseN)
      begin
         shiftIn <= nextByte;
         bitCnt  <= bitCnt + 3'h1;
         if (bitCnt == 3'h7 && linkState == LS_OPCODE)
            linkState <= (nextByte[2:0] == STATUS_READ_CMD) ? LS_READ :
                         ((nextByte[2:1] == 2'b01) ? LS_ADDR : LS_DATA);
         else if (bitCnt == 3'h7 && linkState == LS_ADDR)
            linkState <= (opcode == ARRAY_READ_CMD) ? LS_READ : LS_DATA;
      end
   end

   // Frame words outlive chip select rising; opValid and dataSeen cleared as a new frame opens
   always_ff @(posedge serialClk)
   begin
      if (!chipSelectN && pauseN && bitCnt == 3'h0 && linkState == LS_OPCODE)
      begin
         opValid  <= 1'b0;
         dataSeen <= 1'b0;
      end
      else if (!chipSelectN && pauseN && bitCnt == 3'h7)
      begin
         unique case (linkState)
            LS_OPCODE:
            begin
               opcode  <= nextByte[2:0];
               opValid <= (nextByte[7:4] == 4'h0);
            end
            LS_ADDR: linkAddr <= nextByte;
            LS_DATA:
            begin
               linkData <= nextByte;
               dataSeen <= 1'b1;
            end
            LS_READ: linkAddr <= linkAddr + 8'h01;
         endcase
      end
   end

   assign txByte = (opcode == STATUS_READ_CMD) ? statusLink : arrayLink;

   // Output shifts on falling edge, only while sending read data
   always_ff @(negedge serialClk or posedge chipSelectN)
   begin
      if (chipSelectN)
      begin
         txShift  <= 8'h00;
         txActive <= 1'b0;
      end
      else if (pauseN && linkState == LS_READ)
      begin
         txActive <= 1'b1;
         txShift  <= (bitCnt == 3'h0) ? txByte : {txShift[6:0], 1'b0};
      end
   end

   assign serialOut   = txShift[7];
   assign serialOutEn = txActive && !chipSelectN && pauseN;

   // ------------------------------------------------------------
   // System domain: status register and protection
   // ------------------------------------------------------------
   logic       busy, writeLatch, guardArm;
   logic [1:0] regionGuard;
   logic       hwProtect, frameDone, inRegion;
   logic [31:0] busyCnt;
   logic [2:0]  cmdSys;
   logic        validSys, dataSys;

   // Frame words are stable while chip select is high, so sampled directly
   assign cmdSys   = opcode;
   assign validSys = opValid;
   assign dataSys  = dataSeen;
   assign frameDone = csSync && !csLast;
   assign hwProtect = !guardSync && guardArm;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         csLast <= 1'b1;
      else
         csLast <= csSync;
   end

   spe_region_check uRegion (
      .regionGuard (regionGuard),
      .addr        (linkAddr),
      .inRegion    (inRegion)
   );

   // Internal write timer sets busy
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         busy    <= 1'b0;
         busyCnt <= 32'h0;
      end
      else if (busy)
      begin
         busyCnt <= busyCnt - 32'h1;
         if (busyCnt == 32'h1)
            busy <= 1'b0;
      end
      else if (frameDone && validSys && dataSys && writeLatch &&
               ((cmdSys == STATUS_WRITE_CMD && !hwProtect) ||
                (cmdSys == ARRAY_WRITE_CMD && !inRegion)))
      begin
         busy    <= 1'b1;
         busyCnt <= 32'(WRITE_CYCLES_P);
      end
   end

   // Write latch: set, clear and power-up clear
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         writeLatch <= 1'b0;
      else if (busy && busyCnt == 32'h1)
         writeLatch <= 1'b0;
      else if (frameDone && validSys && !busy)
      begin
         if (cmdSys == SET_WRITE_LATCH_CMD)
            writeLatch <= 1'b1;
         else if (cmdSys == CLEAR_WRITE_LATCH_CMD)
            writeLatch <= 1'b0;
      end
   end

   // Status write applies guard bits unless hardware protected
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         regionGuard <= REGION_GUARD_RESET;
         guardArm    <= ARM_RESET;
      end
      else if (frameDone && validSys && dataSys && !busy && writeLatch && !hwProtect &&
               cmdSys == STATUS_WRITE_CMD)
      begin
         regionGuard <= {linkData[GUARD_HI_BIT], linkData[GUARD_LO_BIT]};
         if (!(guardArm && !guardSync))
            guardArm <= linkData[ARM_BIT];
      end
   end

   // Array write strobe outside protected range; pin guard ignored
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         arrayWriteReq  <= 1'b0;
         arrayWriteAddr <= 8'h00;
         arrayWriteData <= 8'h00;
      end
      else
      begin
         arrayWriteReq <= frameDone && validSys && dataSys && !busy && writeLatch &&
                          cmdSys == ARRAY_WRITE_CMD && !inRegion;
         arrayWriteAddr <= linkAddr;
         arrayWriteData <= linkData;
      end
   end

   // Read view: all ones while busy, spare bits zero
   assign statusView = busy ? ALL_ONES :
                       {guardArm, 3'h0, regionGuard, writeLatch, 1'b0};

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         protectionStatus <= 8'h00;
      else
         protectionStatus <= statusView;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_busy_ones;
      @(posedge clk) disable iff (sys_rst) busy |=> protectionStatus == ALL_ONES;
   endproperty
   a_busy_ones: assert property (p_busy_ones) else $error("busy status not all ones");

   property p_hw_guard;
      @(posedge clk) disable iff (sys_rst)
         hwProtect |=> $stable(regionGuard) && $stable(guardArm);
   endproperty
   a_hw_guard: assert property (p_hw_guard) else $error("guard bits changed under protection");

   property p_latch_gate;
      @(posedge clk) disable iff (sys_rst)
         !writeLatch |=> $stable(regionGuard) && !arrayWriteReq;
   endproperty
   a_latch_gate: assert property (p_latch_gate) else $error("change without write latch");

   property p_arm_hold;
      @(posedge clk) disable iff (sys_rst)
         guardArm && !guardSync |=> guardArm;
   endproperty
   a_arm_hold: assert property (p_arm_hold) else $error("arm bit fell with guard low");

   property p_spare_zero;
      @(posedge clk) disable iff (sys_rst) !busy |=> protectionStatus[6:4] == 3'h0;
   endproperty
   a_spare_zero: assert property (p_spare_zero) else $error("spare bits nonzero");

   property p_busy_latch;
      @(posedge clk) disable iff (sys_rst) $fell(busy) |-> !writeLatch;
   endproperty
   a_busy_latch: assert property (p_busy_latch) else $error("latch set after write");

   property p_region_all;
      @(posedge clk) disable iff (sys_rst) regionGuard == 2'h3 |=> !arrayWriteReq;
   endproperty
   a_region_all: assert property (p_region_all) else $error("write into protected array");

   property p_busy_ignore;
      @(posedge clk) disable iff (sys_rst) busy && !$fell(busy) |=> $stable(guardArm);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

   property p_out_off;
      @(posedge clk) disable iff (sys_rst) chipSelectN |-> !serialOutEn && !txActive;
   endproperty
   a_out_off: assert property (p_out_off) else $error("output driven in standby");
endmodule
`default_nettype wire

// ### hdl/spe_region_check.sv
// Block-protect range decode for an array address
`timescale 1ns/100ps
`default_nettype none
module spe_region_check
   import spe_pkg::*;
(
   // Protection setting and address
   input  wire logic [1:0]        regionGuard,
   input  wire logic [ADDR_W-1:0] addr,
   // Result
   output logic                   inRegion
);
   always_comb
   begin
      unique case (regionGuard)
         2'h0: inRegion = 1'b0;
         2'h1: inRegion = (addr >= 8'hc0);
         2'h2: inRegion = (addr >= 8'h80);
         2'h3: inRegion = 1'b1;
      endcase
   end
endmodule
`default_nettype wire

// ### hdl/spe_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module spe_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stage <= INIT;
         dout  <= INIT;
      end
      else
      begin
         stage <= din;
         dout  <= stage;
      end
   end
endmodule
`default_nettype wire

// ### include/spe_pkg.sv
// Package of constants for the serial status and protection slave
`default_nettype none
package spe_pkg;
   // Status register field positions
   localparam int BUSY_BIT     = 0;
   localparam int LATCH_BIT    = 1;
   localparam int GUARD_LO_BIT = 2;
   localparam int GUARD_HI_BIT = 3;
   localparam int ARM_BIT      = 7;
   localparam logic [7:0] STATUS_WRITE_MASK = 8'h8c;
   localparam logic [7:0] ALL_ONES          = 8'hff;
   // Command codes, low nibble with bit 3 ignored, upper nibble zero
   localparam logic [2:0] SET_WRITE_LATCH_CMD   = 3'h6;
   localparam logic [2:0] CLEAR_WRITE_LATCH_CMD = 3'h4;
   localparam logic [2:0] STATUS_READ_CMD       = 3'h5;
   localparam logic [2:0] STATUS_WRITE_CMD      = 3'h1;
   localparam logic [2:0] ARRAY_READ_CMD        = 3'h3;
   localparam logic [2:0] ARRAY_WRITE_CMD       = 3'h2;
   // Reset values
   localparam logic [1:0] REGION_GUARD_RESET = 2'h0;
   localparam logic       ARM_RESET          = 1'b0;
   // Internal write time
   localparam int WRITE_TIME_US  = 4000;
   localparam int CLK_MHZ        = 100;
   localparam int WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
   localparam int ADDR_W         = 8;
endpackage
`default_nettype wire

// ### sim/spe_master.sv
// Serial link master model for the status and protection slave
`timescale 1ns/100ps
`default_nettype none
module spe_master
(
   // Link outputs
   output logic      serialClk,
   output logic      chipSelectN,
   output logic      serialIn,
   output logic      pauseN,
   // Link inputs
   input  wire logic serialOut,
   input  wire logic serialOutEn
);
   logic mode3;
   logic enAll;
   initial
   begin
      serialClk = 1'b0;
      chipSelectN = 1'b1;
      serialIn = 1'b0;
      pauseN = 1'b1;
      mode3 = 1'b0;
      enAll = 1'b1;
   end
   // Open a frame, clock idles at the mode level
   task automatic start();
      serialClk = mode3;
      #43;
      chipSelectN = 1'b0;
      #40;
   endtask
   // One byte MSB first, optional pause in mid-byte
   task automatic xb(input logic [7:0] tx, input bit doPause, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         serialClk = 1'b0;
         if (doPause && i == 3)
         begin
            #10;
            pauseN = 1'b0;
            #10;
            repeat (4)
            begin
               serialIn = ~serialIn;
               serialClk = 1'b1;
               #40;
               serialClk = 1'b0;
               #40;
            end
            pauseN = 1'b1;
         end
         serialIn = tx[i];
         #40;
         serialClk = 1'b1;
         rx[i] = serialOut;
         enAll = enAll & serialOutEn;
         #40;
      end
   endtask
   // Close the frame, data line no longer holds its value
   task automatic stop();
      if (!mode3)
         serialClk = 1'b0;
      #20;
      chipSelectN = 1'b1;
      serialIn = ~serialIn;
      #97;
   endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the status and protection slave
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import spe_pkg::*;
   localparam int WCYC = 400;
   logic       clk;
   logic       sys_rst;
   logic       writeGuardN;
   logic [7:0] arrayReadData;
   wire        serialClk, chipSelectN, serialIn, pauseN, serialOut, serialOutEn, arrayWriteReq;
   wire  [7:0] arrayWriteAddr, arrayWriteData, protectionStatus;
   int         err_total, n_compared, nReq, badEn;
   logic [7:0] lastAddr, lastData, r, d, a;
   logic [1:0] expRegion;
   logic       expArm, latch;
   spe_protect_status #(.WRITE_CYCLES_P(WCYC)) DUT (.clk(clk), .sys_rst(sys_rst), .serialClk(serialClk),
      .chipSelectN(chipSelectN), .serialIn(serialIn), .pauseN(pauseN), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .writeGuardN(writeGuardN), .arrayWriteReq(arrayWriteReq),
      .arrayWriteAddr(arrayWriteAddr), .arrayWriteData(arrayWriteData), .arrayReadData(arrayReadData),
      .protectionStatus(protectionStatus));
   spe_master m (.serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn), .pauseN(pauseN),
      .serialOut(serialOut), .serialOutEn(serialOutEn));
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      if (arrayWriteReq === 1'b1)
      begin
         nReq++;
         lastAddr = arrayWriteAddr;
         lastData = arrayWriteData;
      end
      if (chipSelectN === 1'b1 && serialOutEn !== 1'b0)
         badEn++;
   end
   function automatic logic [7:0] stExp(input logic l);
      return {expArm, 3'h0, expRegion, l, 1'b0};
   endfunction
   function automatic logic inRegion(input logic [1:0] c, input logic [7:0] ad);
      return (c == 2'h3) || (c == 2'h2 && ad >= 8'h80) || (c == 2'h1 && ad >= 8'hc0);
   endfunction
   task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic cmpBit(input logic got, input logic exp, input string msg);
      cmpByte({7'h0, got}, {7'h0, exp}, msg);
   endtask
   function automatic logic [7:0] op(input logic [2:0] c);
      return {4'h0, 1'($urandom % 2), c};
   endfunction
   task automatic cmd(input logic [2:0] c);
      m.start();
      m.xb(op(c), 0, r);
      m.stop();
   endtask
   task automatic wrSt(input logic [7:0] v);
      m.start();
      m.xb(op(STATUS_WRITE_CMD), 0, r);
      m.xb(v, 0, r);
      m.stop();
   endtask
   task automatic wrAr(input logic [7:0] ad, input logic [7:0] v);
      m.start();
      m.xb(op(ARRAY_WRITE_CMD), 0, r);
      m.xb(ad, 0, r);
      m.xb(v, 0, r);
      m.stop();
   endtask
   // Second status byte, after the crossing has settled
   task automatic rdSt(input logic [7:0] exp);
      m.start();
      m.xb(op(STATUS_READ_CMD), 0, r);
      m.enAll = 1'b1;
      m.xb(8'h00, 0, r);
      m.xb(8'h00, 0, r);
      m.stop();
      cmpByte(r, exp, "link status");
      cmpBit(m.enAll, 1'b1, "output enable");
   endtask
   task automatic waitReady();
      for (int k = 0; k < 2 * WCYC && protectionStatus[BUSY_BIT] !== 1'b0; k++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      #1;
      cmpBit(protectionStatus[BUSY_BIT], 1'b0, "ready");
   endtask
   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #600000;
      err_total++;
      conclude();
   end
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      writeGuardN = 1'b1;
      arrayReadData = 8'h00;
      {err_total, n_compared, nReq, badEn} = '0;
      {expArm, expRegion} = '0;
      void'($urandom(12));
      repeat (5) @(posedge clk);
      #1 sys_rst = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      cmpByte(protectionStatus, 8'h00, "reset");
      cmd(SET_WRITE_LATCH_CMD);
      cmpByte(protectionStatus, 8'h02, "latch set");
      cmd(CLEAR_WRITE_LATCH_CMD);
      cmpByte(protectionStatus, 8'h00, "latch clear");
      wrSt(8'h8c);
      cmpByte(protectionStatus, 8'h00, "write no latch");
      $display("Test latch done");
      for (int c = 0; c < 4; c++)
      begin
         d = (8'($urandom) & 8'h73) | {6'h0, 2'(c)} << 2;
         cmd(SET_WRITE_LATCH_CMD);
         wrSt(d);
         cmpByte(protectionStatus, ALL_ONES, "busy view");
         rdSt(8'hff);
         waitReady();
         expRegion = 2'(c);
         cmpByte(protectionStatus, stExp(0), "status write");
         rdSt(stExp(0));
         for (int i = 0; i < 7; i++)
         begin
            a = (i < 6) ? 8'(48'h00_7f_80_bf_c0_ff >> (8 * i)) : 8'($urandom);
            d = 8'($urandom);
            latch = !(c == 0 && i == 0);
            if (latch)
               cmd(SET_WRITE_LATCH_CMD);
            nReq = 0;
            wrAr(a, d);
            waitReady();
            cmpByte(8'(nReq), {7'h0, latch && !inRegion(2'(c), a)}, "array write");
            if (nReq == 1)
            begin
               cmpByte(lastAddr, a, "array address");
               cmpByte(lastData, d, "array data");
            end
            cmd(CLEAR_WRITE_LATCH_CMD);
         end
      end
      cmd(SET_WRITE_LATCH_CMD);
      wrSt(8'h00);
      waitReady();
      expRegion = 2'h0;
      $display("Test regions done");
      cmd(SET_WRITE_LATCH_CMD);
      wrAr(8'h10, 8'h5a);
      rdSt(8'hff);
      cmd(SET_WRITE_LATCH_CMD);
      waitReady();
      cmpByte(protectionStatus, 8'h00, "busy refuses");
      $display("Test busy done");
      cmd(SET_WRITE_LATCH_CMD);
      wrSt(8'h80);
      waitReady();
      expArm = 1'b1;
      @(posedge clk) #1 writeGuardN = 1'b0;
      repeat (5) @(posedge clk);
      cmd(SET_WRITE_LATCH_CMD);
      wrSt(8'h0c);
      waitReady();
      cmpByte(protectionStatus, stExp(1), "hw guard");
      @(posedge clk) #1 writeGuardN = 1'b1;
      repeat (5) @(posedge clk);
      wrSt(8'h0c);
      waitReady();
      {expArm, expRegion} = 3'h3;
      cmpByte(protectionStatus, stExp(0), "guard released");
      cmd(SET_WRITE_LATCH_CMD);
      wrSt(8'h00);
      waitReady();
      {expArm, expRegion} = 3'h0;
      $display("Test guard done");
      m.start();
      m.xb(op(SET_WRITE_LATCH_CMD), 1, r);
      m.stop();
      cmpByte(protectionStatus, 8'h02, "pause resume");
      cmd(CLEAR_WRITE_LATCH_CMD);
      m.mode3 = 1'b1;
      cmd(SET_WRITE_LATCH_CMD);
      rdSt(8'h02);
      cmd(CLEAR_WRITE_LATCH_CMD);
      m.mode3 = 1'b0;
      @(posedge clk) #1 arrayReadData = 8'($urandom);
      m.start();
      m.xb(op(ARRAY_READ_CMD), 0, r);
      m.xb(8'($urandom), 0, r);
      m.xb(8'h00, 0, r);
      m.stop();
      cmpByte(r, arrayReadData, "array read");
      cmpBit(badEn == 0, 1'b1, "released output");
      $display("Test link done");
      conclude();
   end
endmodule
`default_nettype wire
